// ===== lcb_limit_check.sv
`timescale 1ns/100ps
module lcb_limit_check (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Reading source, signed base-unit value after math
   input  wire logic [31:0] reading_i,
   input  wire logic        reading_valid_i,
   // Digital port
   input  wire logic        cal_in_i,
   output logic      [3:0]  line_o,
   output logic      [3:0]  line_oe_o,
   // Interrupt
   output logic             irq_o
);
   lcb_pkg::lcb_ctrl_t     ctrl_q;
   lcb_pkg::lcb_pats_t     pats_q;
   logic signed [31:0]     s1_lo_q, s1_hi_q, s2_lo_q, s2_hi_q, reading_q;
   logic [3:0]             state_q, state_d, pol_q;
   logic                   strobe_q, strobe_d;
   logic [lcb_pkg::LCB_CNT_W-1:0] stb_cnt_q;
   logic [2:0]             irq_stat_q, irq_mask_q, irq_set;
   logic                   wr, rd, ctl_on_rise, stb_en_rise;
   logic                   v1, v2, f_lo1, f_hi1, f_lo2, f_hi2, any_fail;
   logic [3:0]             fail_pat;
   logic                   eval_q;
   logic                   unused_cal;

   // Merge a write word into a register under byte enables
   function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign unused_cal = cal_in_i;
   assign wr = cyc_i && stb_i && we_i && !ack_o;
   assign rd = cyc_i && stb_i && !we_i && !ack_o;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   logic [31:0] ctrl_w;
   assign ctrl_w = wmask({27'h0, ctrl_q}, dat_i, sel_i);
   assign ctl_on_rise = wr && adr_i == lcb_pkg::LCB_A_CTRL &&
                        ((ctrl_w[lcb_pkg::LCB_C_CTL1] && !ctrl_q.ctl1) ||
                         (ctrl_w[lcb_pkg::LCB_C_CTL2] && !ctrl_q.ctl2));
   assign stb_en_rise = wr && adr_i == lcb_pkg::LCB_A_CTRL && ctrl_w[lcb_pkg::LCB_C_STB] && !ctrl_q.stb_en;

   // Configuration registers; bounds taken as entered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q  <= '0;
         pats_q  <= '0;
         s1_lo_q <= lcb_pkg::LCB_RST_WORD;
         s1_hi_q <= lcb_pkg::LCB_RST_WORD;
         s2_lo_q <= lcb_pkg::LCB_RST_WORD;
         s2_hi_q <= lcb_pkg::LCB_RST_WORD;
         pol_q   <= lcb_pkg::LCB_RST_LINES;
         irq_mask_q <= 3'h0;
      end else if (wr) begin
         if (adr_i == lcb_pkg::LCB_A_CTRL) begin
            ctrl_q <= ctrl_w[4:0];
         end else if (adr_i == lcb_pkg::LCB_A_S1_LO) begin
            s1_lo_q <= wmask(s1_lo_q, dat_i, sel_i);
         end else if (adr_i == lcb_pkg::LCB_A_S1_HI) begin
            s1_hi_q <= wmask(s1_hi_q, dat_i, sel_i);
         end else if (adr_i == lcb_pkg::LCB_A_S2_LO) begin
            s2_lo_q <= wmask(s2_lo_q, dat_i, sel_i);
         end else if (adr_i == lcb_pkg::LCB_A_S2_HI) begin
            s2_hi_q <= wmask(s2_hi_q, dat_i, sel_i);
         end else if (adr_i == lcb_pkg::LCB_A_PATS) begin
            pats_q <= 20'(wmask({12'h0, pats_q}, dat_i, sel_i));
         end else if (adr_i == lcb_pkg::LCB_A_LINES && sel_i[1]) begin
            pol_q <= dat_i[11:8];
         end else if (adr_i == lcb_pkg::LCB_A_IRQ_MASK && sel_i[0]) begin
            irq_mask_q <= dat_i[2:0];
         end
      end
   end

   // Capture reading; tests run the following cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reading_q <= lcb_pkg::LCB_RST_WORD;
         eval_q    <= 1'b0;
      end else begin
         if (reading_valid_i) begin
            reading_q <= reading_i;
         end
         eval_q <= reading_valid_i;
      end
   end

   // Valid set and per-bound fail terms
   always_comb begin
      v1    = ctrl_q.en1 && ctrl_q.ctl1 && (s1_hi_q > s1_lo_q);
      v2    = ctrl_q.en2 && ctrl_q.ctl2 && (s2_hi_q > s2_lo_q);
      f_lo1 = v1 && (reading_q < s1_lo_q);
      f_hi1 = v1 && (reading_q > s1_hi_q);
      f_lo2 = v2 && (reading_q < s2_lo_q);
      f_hi2 = v2 && (reading_q > s2_hi_q);
      any_fail = f_lo1 || f_hi1 || f_lo2 || f_hi2;
      if (f_lo1) begin
         fail_pat = pats_q.lo1;
      end else if (f_hi1) begin
         fail_pat = pats_q.hi1;
      end else if (f_lo2) begin
         fail_pat = pats_q.lo2;
      end else if (f_hi2) begin
         fail_pat = pats_q.hi2;
      end else begin
         fail_pat = pats_q.pass;
      end
   end

   // Logical line states
   always_comb begin
      state_d = state_q;
      if (wr && adr_i == lcb_pkg::LCB_A_LINES && sel_i[0]) begin
         state_d = dat_i[3:0];
      end
      if (ctl_on_rise) begin
         state_d = pats_q.pass;
      end else if (eval_q && (v1 || v2)) begin
         state_d = fail_pat;
      end
      if (ctrl_q.stb_en) begin
         state_d[lcb_pkg::LCB_STB_LINE] = state_q[lcb_pkg::LCB_STB_LINE];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= lcb_pkg::LCB_RST_LINES;
      end else begin
         state_q <= state_d;
      end
   end

   // Binning strobe
   always_comb begin
      strobe_d = strobe_q;
      if (stb_en_rise) begin
         strobe_d = 1'b0;
      end else if (ctrl_q.stb_en && eval_q) begin
         strobe_d = 1'b1;
      end else if (ctrl_q.stb_en && stb_cnt_q == lcb_pkg::LCB_CNT_W'(1)) begin
         strobe_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_q  <= 1'b0;
         stb_cnt_q <= '0;
      end else begin
         strobe_q <= strobe_d;
         if (stb_en_rise || !ctrl_q.stb_en) begin
            stb_cnt_q <= '0;
         end else if (eval_q) begin
            stb_cnt_q <= lcb_pkg::LCB_CNT_W'(lcb_pkg::LCB_STROBE_CYC);
         end else if (stb_cnt_q != '0) begin
            stb_cnt_q <= stb_cnt_q - lcb_pkg::LCB_CNT_W'(1);
         end
      end
   end

   // Pins: open-collector, driven only when the pin level is low
   logic [3:0] logic_lv, pin_lv;
   always_comb begin
      logic_lv = state_q;
      if (ctrl_q.stb_en) begin
         logic_lv[lcb_pkg::LCB_STB_LINE] = strobe_q;
      end
      pin_lv = logic_lv ^ pol_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_o    <= 4'hF;
         line_oe_o <= 4'h0;
      end else begin
         line_o    <= pin_lv;
         line_oe_o <= ~pin_lv;
      end
   end

   // Interrupt status: set wins over read-clear
   assign irq_set = {(s1_lo_q >= s1_hi_q), eval_q && any_fail, eval_q};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= 3'h0;
         irq_o      <= 1'b0;
      end else begin
         if (rd && adr_i == lcb_pkg::LCB_A_IRQ_STAT) begin
            irq_stat_q <= irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (rd) begin
         if (adr_i == lcb_pkg::LCB_A_CTRL) begin
            dat_o <= {27'h0, ctrl_q};
         end else if (adr_i == lcb_pkg::LCB_A_S1_LO) begin
            dat_o <= s1_lo_q;
         end else if (adr_i == lcb_pkg::LCB_A_S1_HI) begin
            dat_o <= s1_hi_q;
         end else if (adr_i == lcb_pkg::LCB_A_S2_LO) begin
            dat_o <= s2_lo_q;
         end else if (adr_i == lcb_pkg::LCB_A_S2_HI) begin
            dat_o <= s2_hi_q;
         end else if (adr_i == lcb_pkg::LCB_A_PATS) begin
            dat_o <= {12'h0, pats_q};
         end else if (adr_i == lcb_pkg::LCB_A_LINES) begin
            dat_o <= {16'h0, logic_lv, pol_q, 4'h0, state_q};
         end else if (adr_i == lcb_pkg::LCB_A_READING) begin
            dat_o <= reading_q;
         end else if (adr_i == lcb_pkg::LCB_A_STATUS) begin
            dat_o <= {24'h0, strobe_q, (s1_lo_q >= s1_hi_q), v2, v1, f_hi2, f_lo2, f_hi1, f_lo1};
         end else if (adr_i == lcb_pkg::LCB_A_IRQ_STAT) begin
            dat_o <= {29'h0, irq_stat_q};
         end else if (adr_i == lcb_pkg::LCB_A_IRQ_MASK) begin
            dat_o <= {29'h0, irq_mask_q};
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end
   end
endmodule

// ===== lcb_pkg.sv
// How it works
// - Two independent limit sets, each enableable
// - Set valid only when upper exceeds lower
// - Compare post-math reading in base units
// - Test order L1,H1,L2,H2; first fail wins
// - All enabled tests pass: apply pass pattern
// - Only control-enabled sets drive output lines
// - Each bound owns its own fail pattern
// - Enabling control loads pass pattern at once
// - Strobe enabled reserves line four for strobe
// - Strobe true over 10 us after tests
// - Enabling strobe forces false; disabling keeps level
// - No entry check; flag set-one lower >= upper
// - Four logical line states, settable and readable
// - Per-line polarity maps logic to pin level
// - Four outputs, one input ignored by limits
// - Active-low: on drives low, off releases high
package lcb_pkg;
   localparam int        LCB_CLK_HZ      = 125000000;
   localparam int        LCB_STROBE_NS   = 10000;
   // Longer than 10 us: one cycle beyond the whole count
   localparam int        LCB_STROBE_CYC  = (LCB_STROBE_NS * (LCB_CLK_HZ / 1000000)) / 1000 + 1;
   localparam int        LCB_CNT_W       = 11;
   localparam int        LCB_LINES       = 4;
   localparam int        LCB_STB_LINE    = 3;

   // Register offsets (byte addresses)
   localparam logic [7:0] LCB_A_CTRL     = 8'h00;
   localparam logic [7:0] LCB_A_S1_LO    = 8'h04;
   localparam logic [7:0] LCB_A_S1_HI    = 8'h08;
   localparam logic [7:0] LCB_A_S2_LO    = 8'h0C;
   localparam logic [7:0] LCB_A_S2_HI    = 8'h10;
   localparam logic [7:0] LCB_A_PATS     = 8'h14;
   localparam logic [7:0] LCB_A_LINES    = 8'h18;
   localparam logic [7:0] LCB_A_READING  = 8'h1C;
   localparam logic [7:0] LCB_A_STATUS   = 8'h20;
   localparam logic [7:0] LCB_A_IRQ_STAT = 8'h24;
   localparam logic [7:0] LCB_A_IRQ_MASK = 8'h28;

   // Control field positions
   localparam int        LCB_C_EN1       = 0;
   localparam int        LCB_C_EN2       = 1;
   localparam int        LCB_C_CTL1      = 2;
   localparam int        LCB_C_CTL2      = 3;
   localparam int        LCB_C_STB       = 4;

   // Pattern register nibbles: lo1, hi1, lo2, hi2, pass
   localparam int        LCB_P_LO1       = 0;
   localparam int        LCB_P_HI1       = 4;
   localparam int        LCB_P_LO2       = 8;
   localparam int        LCB_P_HI2       = 12;
   localparam int        LCB_P_PASS      = 16;

   // Interrupt bits
   localparam int        LCB_I_DONE      = 0;
   localparam int        LCB_I_FAIL      = 1;
   localparam int        LCB_I_BAD1      = 2;

   localparam logic [31:0] LCB_RST_WORD  = 32'h0000_0000;
   localparam logic [3:0]  LCB_RST_LINES = 4'h0;

   typedef struct packed {
      logic        stb_en;
      logic        ctl2;
      logic        ctl1;
      logic        en2;
      logic        en1;
   } lcb_ctrl_t;

   typedef struct packed {
      logic [3:0]  pass;
      logic [3:0]  hi2;
      logic [3:0]  lo2;
      logic [3:0]  hi1;
      logic [3:0]  lo1;
   } lcb_pats_t;
endpackage

// ===== lcb_limit_check_checker.sv
`timescale 1ns/100ps
module lcb_limit_check_checker (
   // Clock, reset and bus
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // Readings, port and interrupt
   input wire logic [31:0] reading_i,
   input wire logic        reading_valid_i,
   input wire logic        cal_in_i,
   input wire logic [3:0]  line_o,
   input wire logic [3:0]  line_oe_o,
   input wire logic        irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [2:0] quiet_q;
   // Cycles since the last reading or bus write
   always_ff @(posedge clk_i) begin
      if (rst_i || reading_valid_i || (cyc_i && stb_i && we_i)) begin
         quiet_q <= 3'h0;
      end else if (quiet_q != 3'h7) begin
         quiet_q <= quiet_q + 3'h1;
      end
   end
   ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
   ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
   read_hold_a: assert property ($changed(dat_o) |-> ack_o) else $error("read data moved");
   unmapped_zero_a: assert property (ack_o && $past(!we_i && adr_i > 8'h28) |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   pin_drive_a: assert property (line_oe_o == ~line_o) else $error("enable not tied to low pin");
   lines_quiet_a: assert property (quiet_q > 3'h3 |-> $stable(line_o[2:0])) else $error("lines moved");
   irq_clear_a: assert property ($fell(irq_o) |-> ack_o || $past(ack_o) || $past(ack_o, 2))
      else $error("irq fell without access");
endmodule
bind lcb_limit_check lcb_limit_check_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .reading_i(reading_i),
   .reading_valid_i(reading_valid_i), .cal_in_i(cal_in_i), .line_o(line_o), .line_oe_o(line_oe_o), .irq_o(irq_o));

// ===== lcb_handler.sv
`timescale 1ns/100ps
module lcb_handler (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Pin levels and sorted bin
   input  wire logic [3:0] pin_i,
   output logic      [2:0] bin_o
);
   logic strobe_q;
   always_ff @(posedge clk_i) begin
      strobe_q <= pin_i[3];
      if (rst_i) begin
         bin_o <= 3'h0;
      end else if (pin_i[3] && !strobe_q) begin
         bin_o <= pin_i[2:0];
      end
   end
endmodule

// ===== test_limit_check_binning_outputs.sv
`timescale 1ns/100ps
module test_limit_check_binning_outputs;
   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        cyc = 1'h0;
   logic        stb = 1'h0;
   logic        we = 1'h0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdg = 32'h0;
   logic        vld = 1'h0;
   logic        cal = 1'h0;
   logic [31:0] lf = 32'hB3F4;
   logic [31:0] dat_o;
   logic        ack_o;
   logic [3:0]  line_o;
   logic [3:0]  line_oe_o;
   logic        irq_o;
   logic [2:0]  bin;
   logic [63:0] notes[$];
   logic [63:0] note;
   int          n_errors = 0;
   int          comparisons = 0;

   always #4 clk_i = ~clk_i;

   lcb_limit_check i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .reading_i(rdg), .reading_valid_i(vld),
      .cal_in_i(cal), .line_o(line_o), .line_oe_o(line_oe_o), .irq_o(irq_o));
   // Pins are driven low or pulled up
   lcb_handler i_handler (.clk_i(clk_i), .rst_i(rst_i), .pin_i(~line_oe_o), .bin_o(bin));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [3:0] exp_lines(input int r, input logic v2);
      if (r < -100) return 4'h1;
      if (r > 100) return 4'h2;
      if (v2 && r < -10) return 4'h3;
      if (v2 && r > 10) return 4'h4;
      return 4'hA;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // For reads d is the expected data, m the bits compared
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFFFF_FFFF);
      int n;
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      if (!w) begin
         notes.push_back({m, d & m});
      end
      n = 0;
      // Look at ack where it has settled, release after the edge that takes it
      do begin
         @(negedge clk_i);
         n++;
      end while (ack_o !== 1'h1 && n < 20);
      check("ack", {31'h0, ack_o}, 32'h1);
      @(posedge clk_i);
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask

   task automatic feed(input logic [31:0] v);
      @(posedge clk_i);
      rdg <= v;
      vld <= 1'h1;
      cal <= lf[1];
      @(posedge clk_i);
      vld <= 1'h0;
      repeat (4) @(posedge clk_i);
   endtask

   always @(negedge clk_i) begin
      if (ack_o === 1'h1 && we === 1'h0 && notes.size() > 0) begin
         note = notes.pop_front();
         check("read data", dat_o & note[63:32], note[31:0]);
      end
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      close_out();
   end

   initial begin
      int r;
      int cnt;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'h0;
      wb(1'h0, lcb_pkg::LCB_A_CTRL, 32'h0);
      wb(1'h0, 8'h40, 32'h0);
      wb(1'h1, lcb_pkg::LCB_A_LINES, 32'h0000_0305);
      wb(1'h0, lcb_pkg::LCB_A_LINES, 32'h0000_5305);
      repeat (2) @(posedge clk_i);
      check("pins", {28'h0, line_o}, 32'h6);
      wb(1'h1, lcb_pkg::LCB_A_LINES, 32'h0);
      wb(1'h1, lcb_pkg::LCB_A_S1_LO, 32'hFFFF_FF9C);
      wb(1'h1, lcb_pkg::LCB_A_S1_HI, 32'h0000_0064);
      wb(1'h1, lcb_pkg::LCB_A_S2_LO, 32'hFFFF_FFF6);
      wb(1'h1, lcb_pkg::LCB_A_S2_HI, 32'h0000_000A);
      wb(1'h1, lcb_pkg::LCB_A_PATS, 32'h000A_4321);
      wb(1'h1, lcb_pkg::LCB_A_CTRL, 32'h0F);
      repeat (2) @(posedge clk_i);
      check("pass load", {28'h0, line_o}, 32'hA);
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            wb(1'h1, lcb_pkg::LCB_A_S2_HI, 32'hFFFF_FFF6);
         end
         for (int k = 0; k < 12; k++) begin
            lf = lfsr(lf);
            r = (k == 0) ? 100 : (k == 1) ? -101 : $signed(lf[7:0]);
            feed(32'(r));
            check("limit pins", {28'h0, line_o}, {28'h0, exp_lines(r, p == 0)});
         end
      end
      wb(1'h1, lcb_pkg::LCB_A_S1_HI, 32'hFFFF_FF9C);
      wb(1'h0, lcb_pkg::LCB_A_STATUS, 32'h40, 32'h40);
      wb(1'h1, lcb_pkg::LCB_A_S1_HI, 32'h0000_0064);
      wb(1'h1, lcb_pkg::LCB_A_IRQ_MASK, 32'h1);
      wb(1'h0, lcb_pkg::LCB_A_IRQ_STAT, 32'h0, 32'h0);
      feed(32'h0000_00C8);
      check("irq", {31'h0, irq_o}, 32'h1);
      wb(1'h0, lcb_pkg::LCB_A_IRQ_STAT, 32'h1, 32'h1);
      repeat (2) @(posedge clk_i);
      check("irq clear", {31'h0, irq_o}, 32'h0);
      wb(1'h1, lcb_pkg::LCB_A_IRQ_MASK, 32'h0);
      feed(32'h0000_00C8);
      check("irq masked", {31'h0, irq_o}, 32'h0);
      wb(1'h1, lcb_pkg::LCB_A_CTRL, 32'h03);
      wb(1'h1, lcb_pkg::LCB_A_LINES, 32'h5);
      feed(32'h0000_00C8);
      check("manual pins", {28'h0, line_o}, 32'h5);
      wb(1'h1, lcb_pkg::LCB_A_CTRL, 32'h0);
      wb(1'h1, lcb_pkg::LCB_A_CTRL, 32'h1F);
      repeat (2) @(posedge clk_i);
      check("strobe idle", {28'h0, line_o}, 32'h2);
      feed(32'h0000_00C8);
      check("strobe pins", {28'h0, line_o}, 32'hA);
      check("bin", {29'h0, bin}, 32'h2);
      cnt = 0;
      while (line_o[3] === 1'h1 && cnt < 3000) begin
         @(negedge clk_i);
         cnt++;
      end
      check("strobe long", {31'h0, cnt > 1249}, 32'h1);
      feed(32'h0000_00C8);
      wb(1'h1, lcb_pkg::LCB_A_CTRL, 32'h0F);
      check("strobe kept", {31'h0, line_o[3]}, 32'h1);
      close_out();
   end
endmodule
